// file: rtl/cfg_chain_defines.vh
// Constants of the serial configuration chain loader
`ifndef CFG_CHAIN_DEFINES_VH
`define CFG_CHAIN_DEFINES_VH

// Number of setup bits held by one device
`define CFG_CHAIN_LEN        16'h0100
// Width of the bit counter
`define CFG_CNT_W            16
// Reset values
`define CFG_CNT_RST          16'h0000
`define CFG_DONE_N_RST       1'b1
`define CFG_SETUP_RST        1'b0
`define CFG_PHASE_RST        2'h0
`define CFG_SO_RST           1'h0
`define CFG_READY_RST        1'h0
`define CFG_ACCEPT_RST       1'h0
// Counts: index of the final setup bit and the count step
`define CFG_CNT_LAST         16'h00ff
`define CFG_CNT_STEP         16'h0001

`endif

// file: rtl/sync_edge.v
// Two-flop synchroniser with a rising edge detector
`timescale 1ns/1ps
`default_nettype none

module sync_edge (
   input  wire sys_clk,
   input  wire rst,
   input  wire din,
   output reg  level_r,
   output reg  rise_r
);

   reg meta_r;
   reg sync_r;

   always @(posedge sys_clk) begin
      if (rst) begin
         meta_r  <= 1'b0;
         sync_r  <= 1'b0;
         level_r <= 1'b0;
         rise_r  <= 1'b0;
      end else begin
         meta_r  <= din;
         sync_r  <= meta_r;
         level_r <= sync_r;
         rise_r  <= sync_r & ~level_r;
      end
   end

endmodule // sync_edge

`default_nettype wire

// file: rtl/serial_config_chain_loader.v
// Serial configuration chain loader of a multi-queue device
//
// How it works
// - A bit is captured on each rising shift clock while enable is low, until all 256 bits are in.
// - Setup storage is a shift register advancing one place per enabled edge.
// - The done output reports that programming has finished.
// - Once programmed, done follows the load enable level.
// - Normal queue operation is allowed only while done is low.
// - Once loaded with done low, serial input passes through to the output.
// - Done going low serves as the load enable of the next device in a chain.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_chain_defines.vh"

module serial_config_chain_loader (
   input  wire                        sys_clk,
   input  wire                        rst,
   input  wire                        serial_shift_clk,
   input  wire                        serial_load_enable_in_n,
   input  wire                        serial_data_in,
   input  wire                        default_setup,
   input  wire                        write_queue_select_enable,
   output reg                         serial_load_done_out_n,
   output reg                         serial_data_out,
   output reg                         queue_select_accept_r,
   output reg                         ready_r,
   output reg  [`CFG_CHAIN_LEN-1:0]   setup_r
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   wire sclk_rise;
   wire en_lvl;
   wire si_lvl;
   reg  en_meta_r;
   reg  en_sync_r;
   reg  si_meta_r;
   reg  si_sync_r;
   reg  wsel_meta_r;
   reg  wsel_sync_r;
   reg  dflt_meta_r;
   reg  dflt_sync_r;

   sync_edge u_sclk (
      .sys_clk (sys_clk),
      .rst     (rst),
      .din     (serial_shift_clk),
      .level_r (),
      .rise_r  (sclk_rise)
   );

   // Enable and data get one extra stage to line up with the edge flag
   always @(posedge sys_clk) begin
      if (rst) begin
         en_meta_r   <= 1'b1;
         en_sync_r   <= 1'b1;
         si_meta_r   <= 1'b0;
         si_sync_r   <= 1'b0;
         wsel_meta_r <= 1'b0;
         wsel_sync_r <= 1'b0;
         dflt_meta_r <= 1'b0;
         dflt_sync_r <= 1'b0;
      end else begin
         en_meta_r   <= serial_load_enable_in_n;
         en_sync_r   <= en_meta_r;
         si_meta_r   <= serial_data_in;
         si_sync_r   <= si_meta_r;
         wsel_meta_r <= write_queue_select_enable;
         wsel_sync_r <= wsel_meta_r;
         dflt_meta_r <= default_setup;
         dflt_sync_r <= dflt_meta_r;
      end
   end

   reg en_d_r;
   reg si_d_r;
   always @(posedge sys_clk) begin
      if (rst) begin
         en_d_r <= 1'b1;
         si_d_r <= 1'b0;
      end else begin
         en_d_r <= en_sync_r;
         si_d_r <= si_sync_r;
      end
   end
   assign en_lvl = en_d_r;
   assign si_lvl = si_d_r;

   // ------------------------------------------------------------
   // Load phase
   // ------------------------------------------------------------
   localparam [1:0] PH_WAIT  = 2'h0;
   localparam [1:0] PH_SHIFT = 2'h1;
   localparam [1:0] PH_DONE  = 2'h2;

   reg  [1:0]            phase_r;
   reg  [1:0]            phase_nxt;
   reg  [`CFG_CNT_W-1:0] cnt_r;
   wire                  loaded;
   wire                  shift_en;
   wire                  take_bit;

   // Decodes the count at which the final setup bit arrives
   function last_bit;
      input [`CFG_CNT_W-1:0] cnt;
      begin
         last_bit = (cnt == `CFG_CNT_LAST);
      end
   endfunction

   assign loaded   = (phase_r == PH_DONE);
   // Shifting stops once loaded so later bits go through, not in
   assign shift_en = sclk_rise & ~en_lvl & ~loaded;
   // Default setup wins over a shift edge in the same cycle
   assign take_bit = shift_en & ~dflt_sync_r;

   always @* begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_WAIT: begin
            if (dflt_sync_r) begin
               phase_nxt = PH_DONE;
            end else if (take_bit && last_bit(cnt_r)) begin
               phase_nxt = PH_DONE;
            end else if (take_bit) begin
               phase_nxt = PH_SHIFT;
            end
         end
         PH_SHIFT: begin
            if (dflt_sync_r) begin
               phase_nxt = PH_DONE;
            end else if (take_bit && last_bit(cnt_r)) begin
               phase_nxt = PH_DONE;
            end
         end
         PH_DONE: begin
            // Loaded state lasts until the next reset
            phase_nxt = PH_DONE;
         end
         default: begin
            phase_nxt = PH_WAIT;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         phase_r <= `CFG_PHASE_RST;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // ------------------------------------------------------------
   // Setup shift register and bit count
   // ------------------------------------------------------------
   // Default setup keeps the reset contents of the chain
   always @(posedge sys_clk) begin
      if (rst) begin
         setup_r <= {`CFG_CHAIN_LEN{`CFG_SETUP_RST}};
      end else if (take_bit) begin
         setup_r <= {setup_r[`CFG_CHAIN_LEN-2:0], si_lvl};
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= `CFG_CNT_RST;
      end else if (take_bit) begin
         cnt_r <= cnt_r + `CFG_CNT_STEP;
      end
   end

   // ------------------------------------------------------------
   // Done, pass-through and queue select gating
   // ------------------------------------------------------------
   reg done_n_nxt;
   reg so_nxt;
   reg accept_nxt;

   always @* begin
      // Held high until loaded, then mirrors the enable
      done_n_nxt = loaded ? en_lvl : `CFG_DONE_N_RST;
      // Sampled, so it lags the pin by the synchroniser depth
      so_nxt     = (loaded & ~en_lvl) ? si_lvl : `CFG_SO_RST;
      // Selections before completion are dropped
      accept_nxt = wsel_sync_r & ~serial_load_done_out_n;
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         serial_load_done_out_n <= `CFG_DONE_N_RST;
      end else begin
         serial_load_done_out_n <= done_n_nxt;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         serial_data_out <= `CFG_SO_RST;
      end else begin
         serial_data_out <= so_nxt;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         ready_r <= `CFG_READY_RST;
      end else begin
         ready_r <= ~done_n_nxt;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         queue_select_accept_r <= `CFG_ACCEPT_RST;
      end else begin
         queue_select_accept_r <= accept_nxt;
      end
   end

endmodule // serial_config_chain_loader

`default_nettype wire

// file: bench/cfg_loader_asserts.sv
// Port checker of the serial configuration loader
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_asserts (
   input wire logic         sys_clk,
   input wire logic         rst,
   input wire logic         serial_load_enable_in_n,
   input wire logic         serial_load_done_out_n,
   input wire logic         serial_data_in,
   input wire logic         serial_data_out,
   input wire logic         queue_select_accept_r,
   input wire logic         ready_r,
   input wire logic [255:0] setup_r
);
   wire en = serial_load_enable_in_n;
   wire dn = serial_load_done_out_n;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_RDY: assert property ($fell(dn) |-> ##[0:1] ready_r)
      else $error("ready late");
   AST_ACC: assert property (dn [*3] |-> !queue_select_accept_r)
      else $error("early select");
   AST_FOLLOW: assert property (ready_r ##0 en [*7] |-> dn)
      else $error("done stuck");
   AST_FALL: assert property ($fell(dn) |-> !$past(en, 3))
      else $error("done fell");
   AST_CAP: assert property (!$stable(setup_r) |-> !$past(en, 3))
      else $error("stray shift");
   AST_STEP: assert property (!$stable(setup_r) |->
      setup_r[255:1] == $past(setup_r[254:0])) else $error("bad shift");
   AST_HOLD: assert property (ready_r |=> $stable(setup_r))
      else $error("late shift");
   AST_PASS: assert property ((ready_r && !en &&
      $stable(serial_data_in)) [*6] |-> serial_data_out == serial_data_in)
      else $error("no pass");
endmodule // cfg_loader_asserts
bind serial_config_chain_loader cfg_loader_asserts chk (
   .sys_clk                 (sys_clk),
   .rst                     (rst),
   .serial_load_enable_in_n (serial_load_enable_in_n),
   .serial_load_done_out_n  (serial_load_done_out_n),
   .serial_data_in          (serial_data_in),
   .serial_data_out         (serial_data_out),
   .queue_select_accept_r   (queue_select_accept_r),
   .ready_r                 (ready_r),
   .setup_r                 (setup_r)
);
`default_nettype wire

// file: bench/cfg_host.sv
// Behavioural host clocking setup bits into the loader
`timescale 1ns/1ps
`default_nettype none
module cfg_host (output var logic sck, output var logic sd);
   initial {sck, sd} = 2'h0; // Clock stands low between frames
   task automatic send(input int n, input logic [255:0] b);
      for (int i = n - 1; i >= 0; i--) begin
         sd = b[i];
         #40 sck = 1'h1;
         #40 sck = 1'h0;
      end
   endtask
   task automatic hold(input logic v); // Data level between frames
      sd = v;
   endtask
endmodule // cfg_host
`default_nettype wire

// file: bench/serial_config_chain_loader_tb_top.sv
// Self-checking bench of the serial configuration chain loader
`timescale 1ns/1ps
`default_nettype none
module serial_config_chain_loader_tb_top;
   localparam logic [255:0] PAT = {16{16'ha5c3}};
   logic sys_clk = 1'h0, rst = 1'h1, dset = 1'h0, en_n = 1'h1, sel = 1'h0;
   logic sck, sd, dn, so, acc, rdy;
   logic [255:0] setup;
   int fail_count = 0, checked = 0;
   wire [3:0] st = {dn, rdy, acc, so};
   cfg_host host (.sck(sck), .sd(sd));
   serial_config_chain_loader dut (.sys_clk(sys_clk), .rst(rst),
      .serial_shift_clk(sck), .serial_load_enable_in_n(en_n),
      .serial_data_in(sd), .default_setup(dset),
      .write_queue_select_enable(sel), .serial_load_done_out_n(dn),
      .serial_data_out(so), .queue_select_accept_r(acc), .ready_r(rdy),
      .setup_r(setup));
   initial forever #4 sys_clk = ~sys_clk;
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      give_verdict();
   end
   task chk(input logic [255:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wchk(input int n, input logic [3:0] e);
      repeat (n) @(negedge sys_clk);
      chk(st, e);
   endtask
   task t_early;
      sel = 1'h1;
      host.send(4, PAT);
      wchk(8, 4'h8);
      chk(setup, 0);
   endtask
   task t_load;
      en_n = 1'h0;
      sel = 1'h0;
      host.send(255, PAT >> 1);
      wchk(8, 4'h8);
      host.send(1, PAT);
      wchk(8, 4'h5);
      chk(setup, PAT);
      sel = 1'h1;
      host.hold(1'h0);
      wchk(6, 4'h6);
      host.send(2, 2'h1);
      wchk(8, 4'h7);
      chk(setup, PAT);
   endtask
   task t_follow;
      en_n = 1'h1;
      wchk(8, 4'h8);
      en_n = 1'h0;
      wchk(8, 4'h7);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      rst = 1'h0;
      t_early();
      t_load();
      t_follow();
      rst = 1'h1;
      dset = 1'h1;
      wchk(8, 4'h8);
      rst = 1'h0;
      wchk(10, 4'h7);
      give_verdict();
   end
endmodule // serial_config_chain_loader_tb_top
`default_nettype wire
